// ### core/t2cr_top.sv
// Timer 2 counter core: capture, auto-reload, up/down and baud modes
`timescale 1ns/1ns
`default_nettype none
module t2cr_top
  import t2cr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run_enable,
  input wire logic i_counter_select,
  input wire logic i_capture_select,
  input wire logic i_updown_enable,
  input wire logic i_ext_trigger_enable,
  input wire logic i_rx_baud_select,
  input wire logic i_tx_baud_select,
  input wire logic i_count_input_pin,
  input wire logic i_ext_trigger_pin,
  input wire logic [7:0] i_wdata,
  input wire logic i_count_low_wr,
  input wire logic i_count_high_wr,
  input wire logic i_capture_low_wr,
  input wire logic i_capture_high_wr,
  input wire logic i_overflow_clear,
  input wire logic i_ext_event_clear,
  output logic [7:0] o_count_low_byte,
  output logic [7:0] o_count_high_byte,
  output logic [7:0] o_capture_low_byte,
  output logic [7:0] o_capture_high_byte,
  output logic o_overflow_flag,
  output logic o_ext_event_flag,
  output logic o_irq,
  output logic o_baud_tick
);
  t2cr_if link ();
  t2cr_mode_t mode;
  logic [15:0] count;
  logic [15:0] capture;
  logic [15:0] next_count;
  logic load_count;
  logic do_capture;
  logic set_ovf;
  logic set_ext;
  logic tog_ext;
  logic baud_roll;
  logic trig_event;

  t2cr_tick u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run_enable(i_run_enable),
    .i_counter_select(i_counter_select),
    .i_count_input_pin(i_count_input_pin),
    .i_ext_trigger_pin(i_ext_trigger_pin),
    .bus(link.src)
  );

  // Mode decode, baud selects take priority
  always_comb begin
    if (i_rx_baud_select || i_tx_baud_select) begin
      mode = T2CR_BAUD;
    end else if (i_capture_select) begin
      mode = T2CR_CAPTURE;
    end else if (i_updown_enable) begin
      mode = T2CR_UPDOWN;
    end else begin
      mode = T2CR_RELOAD;
    end
  end

  assign trig_event = link.trig_fall & i_ext_trigger_enable;

  // Next count and event decode per mode
  always_comb begin
    next_count = count;
    load_count = 1'b0;
    do_capture = 1'b0;
    set_ovf = 1'b0;
    set_ext = 1'b0;
    tog_ext = 1'b0;
    baud_roll = 1'b0;
    case (mode)
      T2CR_CAPTURE: begin
        if (link.count_tick) begin
          load_count = 1'b1;
          next_count = count + COUNT_ONE;
          set_ovf = (count == COUNT_MAX);
        end
        if (trig_event) begin
          do_capture = 1'b1;
          set_ext = 1'b1;
        end
      end
      T2CR_RELOAD: begin
        if (trig_event) begin
          load_count = 1'b1;
          next_count = capture;
          set_ext = 1'b1;
        end else if (link.count_tick) begin
          load_count = 1'b1;
          if (count == COUNT_MAX) begin
            next_count = capture;
            set_ovf = 1'b1;
          end else begin
            next_count = count + COUNT_ONE;
          end
        end
      end
      T2CR_UPDOWN: begin
        if (link.count_tick) begin
          load_count = 1'b1;
          if (i_ext_trigger_pin) begin
            if (count == COUNT_MAX) begin
              next_count = capture;
              set_ovf = 1'b1;
              tog_ext = 1'b1;
            end else begin
              next_count = count + COUNT_ONE;
            end
          end else begin
            if (count == capture) begin
              next_count = COUNT_MAX;
              set_ovf = 1'b1;
              tog_ext = 1'b1;
            end else begin
              next_count = count - COUNT_ONE;
            end
          end
        end
      end
      T2CR_BAUD: begin
        if (link.count_tick) begin
          load_count = 1'b1;
          if (count == COUNT_MAX) begin
            next_count = capture;
            baud_roll = 1'b1;
          end else begin
            next_count = count + COUNT_ONE;
          end
        end
        set_ext = trig_event;
      end
      default: begin
        next_count = count;
      end
    endcase
  end

  // Count register; a software byte write wins over counting
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= COUNT_RST;
    end else begin
      if (load_count) begin
        count <= next_count;
      end
      if (i_count_low_wr) begin
        count[LOW_LSB +: 8] <= i_wdata;
      end
      if (i_count_high_wr) begin
        count[HIGH_LSB +: 8] <= i_wdata;
      end
    end
  end

  // Capture/reload pair; a capture event wins over a software write
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      capture <= COUNT_RST;
    end else if (do_capture) begin
      capture <= count;
    end else begin
      if (i_capture_low_wr) begin
        capture[LOW_LSB +: 8] <= i_wdata;
      end
      if (i_capture_high_wr) begin
        capture[HIGH_LSB +: 8] <= i_wdata;
      end
    end
  end

  // Flags: hardware set or toggle beats a software clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_overflow_flag <= 1'b0;
      o_ext_event_flag <= 1'b0;
    end else begin
      if (set_ovf) begin
        o_overflow_flag <= 1'b1;
      end else if (i_overflow_clear) begin
        o_overflow_flag <= 1'b0;
      end
      if (tog_ext) begin
        o_ext_event_flag <= ~o_ext_event_flag;
      end else if (set_ext) begin
        o_ext_event_flag <= 1'b1;
      end else if (i_ext_event_clear) begin
        o_ext_event_flag <= 1'b0;
      end
    end
  end

  // Baud pulse toward the serial port
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_baud_tick <= 1'b0;
    end else begin
      o_baud_tick <= baud_roll;
    end
  end

  assign o_count_low_byte = count[LOW_LSB +: 8];
  assign o_count_high_byte = count[HIGH_LSB +: 8];
  assign o_capture_low_byte = capture[LOW_LSB +: 8];
  assign o_capture_high_byte = capture[HIGH_LSB +: 8];
  // Interrupt request; ext flag masked in up/down mode
  assign o_irq = o_overflow_flag | (o_ext_event_flag & (mode != T2CR_UPDOWN));

  logic no_wr;
  assign no_wr = !(i_count_low_wr || i_count_high_wr || i_capture_low_wr || i_capture_high_wr);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_capture_roll: assert property (
    (mode == T2CR_CAPTURE && link.count_tick && count == COUNT_MAX && no_wr)
    |=> (o_overflow_flag && count == COUNT_RST && o_irq))
    else $error("capture rollover wrong");
  chk_capture_copy: assert property (
    (mode == T2CR_CAPTURE && trig_event) |=> (capture == $past(count) && o_ext_event_flag))
    else $error("capture copy wrong");
  chk_reload_roll: assert property (
    (mode == T2CR_RELOAD && link.count_tick && !trig_event && count == COUNT_MAX && no_wr)
    |=> (count == $past(capture) && o_overflow_flag))
    else $error("up reload wrong");
  chk_reload_trig: assert property (
    (mode == T2CR_RELOAD && trig_event && no_wr)
    |=> (count == $past(capture) && o_ext_event_flag))
    else $error("forced reload wrong");
  chk_up_count: assert property (
    (mode == T2CR_UPDOWN && link.count_tick && i_ext_trigger_pin && count != COUNT_MAX && no_wr)
    |=> count == $past(count) + COUNT_ONE)
    else $error("up count wrong");
  chk_down_load: assert property (
    (mode == T2CR_UPDOWN && link.count_tick && !i_ext_trigger_pin && count == capture && no_wr)
    |=> (count == COUNT_MAX && o_ext_event_flag != $past(o_ext_event_flag)))
    else $error("down limit load wrong");
  chk_down_count: assert property (
    (mode == T2CR_UPDOWN && link.count_tick && !i_ext_trigger_pin && count != capture && no_wr)
    |=> count == $past(count) - COUNT_ONE)
    else $error("down count wrong");
  chk_updown_noirq: assert property (
    (mode == T2CR_UPDOWN && !o_overflow_flag) |-> !o_irq)
    else $error("ext flag raised irq in up/down");
  chk_baud_noovf: assert property (
    (mode == T2CR_BAUD && link.count_tick && count == COUNT_MAX && !o_overflow_flag)
    |=> (!o_overflow_flag && o_baud_tick))
    else $error("baud rollover wrong");
  chk_baud_trig: assert property (
    (mode == T2CR_BAUD && trig_event) |=> (o_ext_event_flag && o_irq))
    else $error("baud trigger flag wrong");
  chk_baud_mode: assert property (
    ((i_rx_baud_select || i_tx_baud_select) && link.count_tick && count == COUNT_MAX && no_wr)
    |=> (count == $past(capture) && o_baud_tick))
    else $error("baud select not honoured");
  cov_capture: cover property (mode == T2CR_CAPTURE && trig_event);
  cov_reload: cover property (mode == T2CR_RELOAD && set_ovf);
  cov_down_load: cover property (mode == T2CR_UPDOWN && tog_ext && !i_ext_trigger_pin);
  cov_baud: cover property (o_baud_tick);
endmodule : t2cr_top
`default_nettype wire

// ### core/t2cr_pkg.sv
// Constants and types shared by the timer 2 capture/reload block
package t2cr_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int DIV_RATIO = 12;
  localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] DIV_ONE = 4'h1;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 8;
  // Operating mode, one-hot
  typedef enum logic [3:0] {
    T2CR_CAPTURE = 4'h1,
    T2CR_RELOAD = 4'h2,
    T2CR_UPDOWN = 4'h4,
    T2CR_BAUD = 4'h8
  } t2cr_mode_t;
endpackage : t2cr_pkg

// ### core/t2cr_if.sv
// Carrier between the clock/edge front end and the counter core
`timescale 1ns/1ns
`default_nettype none
interface t2cr_if;
  logic count_tick;
  logic trig_fall;
  modport src (output count_tick, output trig_fall);
  modport dst (input count_tick, input trig_fall);
endinterface : t2cr_if
`default_nettype wire

// ### core/t2cr_tick.sv
// Count clock selection, divide-by-12 time base and pin edge detection
`timescale 1ns/1ns
`default_nettype none
module t2cr_tick
  import t2cr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run_enable,
  input wire logic i_counter_select,
  input wire logic i_count_input_pin,
  input wire logic i_ext_trigger_pin,
  t2cr_if.src bus
);
  logic [3:0] div_cnt;
  logic div_tick;
  logic count_prev;
  logic trig_prev;

  // Divide the system clock by 12
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt <= DIV_RST;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= DIV_RST;
    end else begin
      div_cnt <= div_cnt + DIV_ONE;
    end
  end
  assign div_tick = (div_cnt == DIV_LAST);

  // Previous pin samples for falling edge detection
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_prev <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      count_prev <= i_count_input_pin;
      trig_prev <= i_ext_trigger_pin;
    end
  end

  // High then low samples mark a falling edge
  assign bus.trig_fall = trig_prev & ~i_ext_trigger_pin;
  // Source select and run gating
  assign bus.count_tick = i_run_enable &
    (i_counter_select ? (count_prev & ~i_count_input_pin) : div_tick);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_tick_gated: assert property (!i_run_enable |-> !bus.count_tick)
    else $error("count tick while stopped");
  chk_div_spacing: assert property (
    (div_tick && !i_counter_select) |=> !div_tick [*8])
    else $error("time base pulses too close");
endmodule : t2cr_tick
`default_nettype wire

// ### sim/t2cr_pins.sv
// Model of the external count pin and the trigger/direction pin
`timescale 1ns/1ns
`default_nettype none
module t2cr_pins (
  input wire logic i_clk,
  output var logic o_count_input_pin,
  output var logic o_ext_trigger_pin
);
  // Both pins rest low so that no edge is seen after reset
  initial begin
    o_count_input_pin = 1'b0;
    o_ext_trigger_pin = 1'b0;
  end
  // Count pin high for hi samples, then low: one falling edge
  task automatic pulse_count(input int hi);
    @(negedge i_clk);
    o_count_input_pin = 1'b1;
    repeat (hi) @(negedge i_clk);
    o_count_input_pin = 1'b0;
  endtask : pulse_count
  // Trigger pin high for one sample, then low
  task automatic trig_fall;
    @(negedge i_clk);
    o_ext_trigger_pin = 1'b1;
    @(negedge i_clk);
    o_ext_trigger_pin = 1'b0;
  endtask : trig_fall
  // Direction level, changed only between count pulses
  task automatic set_dir(input logic up);
    @(negedge i_clk);
    o_ext_trigger_pin = up;
  endtask : set_dir
endmodule : t2cr_pins
`default_nettype wire

// ### sim/timer2_capture_reload_test.sv
// Self-checking bench for the timer 2 capture/reload block
`timescale 1ns/1ns
`default_nettype none
module timer2_capture_reload_test;
  import t2cr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic csel = 1'b1;
  logic cap = 1'b1;
  logic ud = 1'b0;
  logic ten = 1'b1;
  logic rxb = 1'b0;
  logic txb = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [3:0] wr = 4'h0; // Count low/high, capture low/high strobes
  logic [1:0] clr = 2'h0; // Overflow clear, ext clear
  wire logic cpin;
  wire logic tpin;
  wire logic [7:0] cl;
  wire logic [7:0] ch;
  wire logic [7:0] rl;
  wire logic [7:0] rh;
  wire logic ovf;
  wire logic ext;
  wire logic irq;
  wire logic bt;
  wire logic [15:0] flg;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  // Flags packed as overflow, ext, irq, baud tick
  assign flg = {12'h000, ovf, ext, irq, bt};
  t2cr_pins pins (.i_clk(clk), .o_count_input_pin(cpin), .o_ext_trigger_pin(tpin));
  t2cr_top uut (
    .i_clk(clk), .i_sys_rst(rst), .i_run_enable(run), .i_counter_select(csel),
    .i_capture_select(cap), .i_updown_enable(ud), .i_ext_trigger_enable(ten),
    .i_rx_baud_select(rxb), .i_tx_baud_select(txb), .i_count_input_pin(cpin),
    .i_ext_trigger_pin(tpin), .i_wdata(wd), .i_count_low_wr(wr[0]),
    .i_count_high_wr(wr[1]), .i_capture_low_wr(wr[2]), .i_capture_high_wr(wr[3]),
    .i_overflow_clear(clr[0]), .i_ext_event_clear(clr[1]), .o_count_low_byte(cl),
    .o_count_high_byte(ch), .o_capture_low_byte(rl), .o_capture_high_byte(rh),
    .o_overflow_flag(ovf), .o_ext_event_flag(ext), .o_irq(irq), .o_baud_tick(bt));
  // Clock generator
  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Write a 16-bit value, sel 0 for the count, 2 for the capture pair
  task automatic wr16(input int sel, input logic [15:0] v);
    @(negedge clk);
    wd = v[7:0];
    wr = 4'h1 << sel;
    @(negedge clk);
    wd = v[15:8];
    wr = 4'h2 << sel;
    @(negedge clk);
    wr = 4'h0;
  endtask : wr16
  task automatic clear(input logic [1:0] which);
    @(negedge clk);
    clr = which;
    @(negedge clk);
    clr = 2'h0;
  endtask : clear
  // One count pulse, then let its update land
  task automatic step(input int hi);
    pins.pulse_count(hi);
    @(negedge clk);
  endtask : step
  task automatic trig;
    pins.trig_fall();
    @(negedge clk);
  endtask : trig
  task automatic t_capture;
    cap = 1'b1;
    wr16(0, 16'hFFFF);
    step(3);
    chk({ch, cl}, 16'h0000);
    chk(flg, 16'h000A);
    wr16(0, 16'h1234);
    trig();
    chk({rh, rl}, 16'h1234);
    chk(flg, 16'h000E);
    clear(2'h3);
    // Trigger edge with the enable off must be ignored
    ten = 1'b0;
    wr16(0, 16'h5678);
    trig();
    chk({rh, rl}, 16'h1234);
    chk(flg, 16'h0000);
    ten = 1'b1;
  endtask : t_capture
  task automatic t_reload;
    cap = 1'b0;
    wr16(2, 16'hABCD);
    wr16(0, 16'hFFFE);
    step(1);
    chk({ch, cl}, 16'hFFFF);
    chk(flg, 16'h0000);
    step(1);
    chk({ch, cl}, 16'hABCD);
    chk(flg, 16'h000A);
    wr16(0, 16'h0100);
    trig();
    chk({ch, cl}, 16'hABCD);
    chk(flg, 16'h000E);
    clear(2'h3);
  endtask : t_reload
  task automatic t_updown;
    ud = 1'b1;
    wr16(2, 16'h0010);
    wr16(0, 16'h0010);
    pins.set_dir(1'b0);
    step(1);
    chk({ch, cl}, 16'hFFFF);
    chk(flg, 16'h000E);
    clear(2'h1);
    chk(flg, 16'h0004);
    pins.set_dir(1'b1);
    step(1);
    chk({ch, cl}, 16'h0010);
    chk(flg, 16'h000A);
    step(1);
    chk({ch, cl}, 16'h0011);
    pins.set_dir(1'b0);
    step(1);
    chk({ch, cl}, 16'h0010);
    clear(2'h3);
    ud = 1'b0;
  endtask : t_updown
  task automatic t_baud;
    cap = 1'b1;
    txb = 1'b1;
    wr16(2, 16'h5555);
    wr16(0, 16'hFFFF);
    step(1);
    chk({ch, cl}, 16'h5555);
    chk(flg, 16'h0001);
    @(negedge clk);
    chk(flg, 16'h0000);
    txb = 1'b0;
    rxb = 1'b1;
    trig();
    chk(flg, 16'h0006);
    clear(2'h3);
    rxb = 1'b0;
  endtask : t_baud
  task automatic t_clock;
    csel = 1'b0;
    run = 1'b0;
    wr16(0, 16'h0000);
    run = 1'b1;
    repeat (24) @(negedge clk);
    run = 1'b0;
    chk({ch, cl}, 16'h0002);
    repeat (24) @(negedge clk);
    chk({ch, cl}, 16'h0002);
  endtask : t_clock
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    chk({ch, cl}, 16'h0000);
    chk(flg, 16'h0000);
    rst = 1'b0;
    t_capture();
    t_reload();
    t_updown();
    t_baud();
    t_clock();
    stop_test();
  end
endmodule : timer2_capture_reload_test
`default_nettype wire
